// >>> verilog/wwd_watchdog.sv
module wwd_watchdog (
    input  wire logic        sys_clk,         // System clock, 25 MHz.
    input  wire logic        rst_n,           // Asynchronous reset, low.
    input  wire logic [7:0]  s_axi_awaddr,    // Write address.
    input  wire logic        s_axi_awvalid,   // Write address valid.
    output logic             s_axi_awready,   // Write address ready.
    input  wire logic [31:0] s_axi_wdata,     // Write data.
    input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes.
    input  wire logic        s_axi_wvalid,    // Write data valid.
    output logic             s_axi_wready,    // Write data ready.
    output logic [1:0]       s_axi_bresp,     // Write response.
    output logic             s_axi_bvalid,    // Write response valid.
    input  wire logic        s_axi_bready,    // Write response ready.
    input  wire logic [7:0]  s_axi_araddr,    // Read address.
    input  wire logic        s_axi_arvalid,   // Read address valid.
    output logic             s_axi_arready,   // Read address ready.
    output logic [31:0]      s_axi_rdata,     // Read data.
    output logic [1:0]       s_axi_rresp,     // Read response.
    output logic             s_axi_rvalid,    // Read data valid.
    input  wire logic        s_axi_rready,    // Read data ready.
    input  wire logic        debug_state,     // Core is in debug state.
    input  wire logic        idle_state,      // System is idle.
    output logic             wdt_fault,       // Fault to reset controller.
    output logic             core_reset_req,  // Processor reset request.
    output logic             system_reset_req,// All resets request.
    output logic             wdt_irq          // Interrupt, level high.
);

    wwd_pkg::wwd_state_s st_ff;   // Registered state.
    wwd_pkg::wwd_state_s nxt_st;  // Next state.

    logic        aw_take;      // Write address accepted this edge.
    logic        w_take;       // Write data accepted this edge.
    logic        ar_take;      // Read address accepted this edge.
    logic        wr_fire;      // Held write is carried out.
    logic        wr_mapped;    // Held write hits a register.
    logic        rd_mapped;    // Read address hits a register.
    logic        wr_ctrl;      // Write to the control register.
    logic        wr_mode;      // Write to the mode register.
    logic        key_ok;       // Control write carries the right key.
    logic        restart_req;  // Keyed restart request.
    logic        restart_ok;   // Restart inside the window.
    logic        mode_wr;      // Accepted first mode write.
    logic        slow_tick;    // One-cycle slow clock enable.
    logic        presc_tick;   // One-cycle enable every 128 slow ticks.
    logic        halted;       // Debug or idle halt in force.
    logic        run;          // Counter allowed to count.
    logic        unf_ev;       // Underflow event.
    logic        err_ev;       // Early restart event.
    logic        flags_rd;     // Status register read accepted.
    logic [31:0] mode_merged;  // Mode word after byte merge.

    // Merges written bytes into an old word under byte strobes.
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // All next-state logic: bus slave, counter, flags and outputs.
    always_comb
    begin
        nxt_st      = st_ff;
        aw_take     = s_axi_awvalid && st_ff.awready;
        w_take      = s_axi_wvalid && st_ff.wready;
        ar_take     = s_axi_arvalid && st_ff.arready;
        wr_fire     = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
        wr_mapped   = (st_ff.aw_addr == wwd_pkg::CTRL_OFS)
                   || (st_ff.aw_addr == wwd_pkg::MODE_OFS)
                   || (st_ff.aw_addr == wwd_pkg::FLAGS_OFS)
                   || (st_ff.aw_addr == wwd_pkg::ISTAT_OFS)
                   || (st_ff.aw_addr == wwd_pkg::IMASK_OFS);
        rd_mapped   = (s_axi_araddr == wwd_pkg::CTRL_OFS)
                   || (s_axi_araddr == wwd_pkg::MODE_OFS)
                   || (s_axi_araddr == wwd_pkg::FLAGS_OFS)
                   || (s_axi_araddr == wwd_pkg::ISTAT_OFS)
                   || (s_axi_araddr == wwd_pkg::IMASK_OFS);
        wr_ctrl     = wr_fire && (st_ff.aw_addr == wwd_pkg::CTRL_OFS);
        wr_mode     = wr_fire && (st_ff.aw_addr == wwd_pkg::MODE_OFS);
        // The key byte and the restart byte must both be written.
        key_ok      = (st_ff.w_data[wwd_pkg::KEY_MSB:wwd_pkg::KEY_LSB]
                       == wwd_pkg::CTRL_KEY)
                   && st_ff.w_strb[3] && st_ff.w_strb[0];
        restart_req = wr_ctrl && key_ok
                   && st_ff.w_data[wwd_pkg::RESTART_BIT];
        // A window at or above the value never sees the counter above it.
        restart_ok  = restart_req
                   && (st_ff.cnt <= st_ff.mode.restart_window_delta);
        err_ev      = restart_req
                   && (st_ff.cnt > st_ff.mode.restart_window_delta);
        mode_wr     = wr_mode && !st_ff.locked;
        mode_merged = merge_bytes(st_ff.mode, st_ff.w_data, st_ff.w_strb)
                    & wwd_pkg::MODE_WMASK;
        flags_rd    = ar_take && (s_axi_araddr == wwd_pkg::FLAGS_OFS);

        // Write address and data are taken in either order and held.
        if (aw_take)
        begin
            nxt_st.aw_have = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (w_take)
        begin
            nxt_st.w_have = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        if (wr_fire)
        begin
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = wr_mapped ? wwd_pkg::RESP_OKAY
                                       : wwd_pkg::RESP_SLVERR;
        end
        // Ready drops while a half is held so a second one cannot slip in.
        nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
        nxt_st.wready  = !nxt_st.w_have && !nxt_st.bvalid;

        // Reads answer one edge after the address is taken.
        if (st_ff.rvalid && s_axi_rready)
        begin
            nxt_st.rvalid = 1'b0;
        end
        if (ar_take)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = rd_mapped ? wwd_pkg::RESP_OKAY
                                      : wwd_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                wwd_pkg::MODE_OFS:  nxt_st.rdata = st_ff.mode;
                wwd_pkg::FLAGS_OFS: nxt_st.rdata = {30'h0, st_ff.err,
                                                    st_ff.unf};
                wwd_pkg::ISTAT_OFS: nxt_st.rdata = {30'h0, st_ff.istat};
                wwd_pkg::IMASK_OFS: nxt_st.rdata = {30'h0, st_ff.imask};
                default:            nxt_st.rdata = 32'h0;
            endcase
        end
        nxt_st.arready = !nxt_st.rvalid;

        // Slow clock enable from the system clock.
        slow_tick = (st_ff.sdiv == wwd_pkg::SLOW_DIV_MAX);
        nxt_st.sdiv = slow_tick ? 10'h000 : st_ff.sdiv + 10'h001;

        // Prescaler wraps every 128 slow ticks.
        presc_tick = slow_tick && (st_ff.presc == wwd_pkg::PRESC_MAX);
        if (slow_tick)
        begin
            nxt_st.presc = st_ff.presc + 7'h01;
        end

        // Halt inputs only freeze the counter, not the prescaler.
        halted = (debug_state && st_ff.mode.debug_halt)
              || (idle_state && st_ff.mode.idle_halt);
        run    = !st_ff.mode.timer_disable && !halted;
        unf_ev = presc_tick && run && (st_ff.cnt == 12'h000);
        if (presc_tick && run)
        begin
            // Counting below zero reloads and flags the underflow.
            nxt_st.cnt = (st_ff.cnt == 12'h000)
                       ? st_ff.mode.counter_load_value
                       : st_ff.cnt - 12'h001;
        end

        // A mode write and a restart both reload and clear the prescaler.
        if (mode_wr)
        begin
            nxt_st.mode   = wwd_pkg::wwd_mode_s'(mode_merged);
            nxt_st.locked = 1'b1;
            nxt_st.cnt    = mode_merged[11:0];
            nxt_st.presc  = 7'h00;
        end
        else if (restart_ok)
        begin
            nxt_st.cnt   = st_ff.mode.counter_load_value;
            nxt_st.presc = 7'h00;
        end

        // Sticky flags clear on read; a new event in that cycle wins.
        nxt_st.unf = (st_ff.unf && !flags_rd) || unf_ev;
        nxt_st.err = (st_ff.err && !flags_rd) || err_ev;

        // Interrupt status: write one to clear, also cleared by flag read.
        if (wr_fire && (st_ff.aw_addr == wwd_pkg::ISTAT_OFS)
            && st_ff.w_strb[0])
        begin
            nxt_st.istat = st_ff.istat & ~st_ff.w_data[1:0];
        end
        if (flags_rd)
        begin
            nxt_st.istat = 2'h0;
        end
        nxt_st.istat = nxt_st.istat | {err_ev, unf_ev};
        if (wr_fire && (st_ff.aw_addr == wwd_pkg::IMASK_OFS)
            && st_ff.w_strb[0])
        begin
            nxt_st.imask = st_ff.w_data[1:0];
        end

        // Errors always fault; underflow faults only with resets enabled.
        nxt_st.fault = (st_ff.fault && !flags_rd) || err_ev
                    || (unf_ev && st_ff.mode.fault_reset_enable);
        nxt_st.core_rst = nxt_st.fault
                       && nxt_st.mode.fault_reset_enable;
        nxt_st.sys_rst  = nxt_st.core_rst
                       && !nxt_st.mode.core_only_reset_select;
        nxt_st.irq = nxt_st.mode.fault_irq_enable
                  && |(nxt_st.istat & nxt_st.imask);
    end

    // Single register stage; the reset controller feeds its watchdog
    // reset back on rst_n, which clears flags and fault with the rest.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= wwd_pkg::STATE_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state register.
    assign s_axi_awready    = st_ff.awready;
    assign s_axi_wready     = st_ff.wready;
    assign s_axi_bvalid     = st_ff.bvalid;
    assign s_axi_bresp      = st_ff.bresp;
    assign s_axi_arready    = st_ff.arready;
    assign s_axi_rvalid     = st_ff.rvalid;
    assign s_axi_rresp      = st_ff.rresp;
    assign s_axi_rdata      = st_ff.rdata;
    assign wdt_fault        = st_ff.fault;
    assign core_reset_req   = st_ff.core_rst;
    assign system_reset_req = st_ff.sys_rst;
    assign wdt_irq          = st_ff.irq;

    // Checks of the timer behaviour against its causes.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_mode_reload;
        mode_wr |=> (st_ff.cnt == st_ff.mode.counter_load_value)
                    && (st_ff.presc == 7'h00) && st_ff.locked;
    endproperty
    a_mode_reload: assert property (p_mode_reload)
        else $error("mode write did not reload the counter");

    property p_mode_once;
        wr_mode && st_ff.locked |=> $stable(st_ff.mode);
    endproperty
    a_mode_once: assert property (p_mode_once)
        else $error("locked mode register changed");

    property p_restart;
        restart_ok |=> (st_ff.cnt == st_ff.mode.counter_load_value)
                       && (st_ff.presc == 7'h00) && !$rose(st_ff.err);
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart did not reload counter and prescaler");

    property p_bad_key;
        wr_ctrl && !key_ok |-> !restart_req && !err_ev;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("control write without key had an effect");

    property p_early_err;
        restart_req && (st_ff.cnt > st_ff.mode.restart_window_delta)
            |=> st_ff.err && st_ff.fault ##1 st_ff.fault;
    endproperty
    a_early_err: assert property (p_early_err)
        else $error("early restart did not flag an error");

    property p_underflow;
        presc_tick && run && (st_ff.cnt == 12'h000)
            |=> st_ff.unf
                && (st_ff.cnt == st_ff.mode.counter_load_value)
                && (st_ff.fault || !st_ff.mode.fault_reset_enable);
    endproperty
    a_underflow: assert property (p_underflow)
        else $error("underflow not flagged");

    property p_irq_gate;
        wdt_irq |-> st_ff.mode.fault_irq_enable
                    && (st_ff.unf || st_ff.err);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without enable or cause");

    property p_read_clear;
        flags_rd && !unf_ev && !err_ev
            |=> !st_ff.unf && !st_ff.err && !wdt_fault && !wdt_irq;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("status read left flags or fault set");

    property p_halt;
        halted && !mode_wr && !restart_ok |=> $stable(st_ff.cnt);
    endproperty
    a_halt: assert property (p_halt)
        else $error("counter moved while halted");

    property p_tick_rate;
        $changed(st_ff.cnt) |-> $past(presc_tick) || $past(mode_wr)
                                || $past(restart_ok);
    endproperty
    a_tick_rate: assert property (p_tick_rate)
        else $error("counter changed without a prescaler tick");

    property p_reset_sel;
        wdt_fault && st_ff.mode.fault_reset_enable
            |-> core_reset_req
                && (system_reset_req
                    == !st_ff.mode.core_only_reset_select);
    endproperty
    a_reset_sel: assert property (p_reset_sel)
        else $error("reset request does not follow select bit");

    // A fault with no cause would reset the system for nothing.
    property p_window_open;
        restart_req && (st_ff.mode.restart_window_delta
                        >= st_ff.mode.counter_load_value)
            |=> !$rose(st_ff.err);
    endproperty
    a_window_open: assert property (p_window_open)
        else $error("restart inside an open window flagged an error");

    property p_fault_cause;
        $rose(st_ff.fault) |-> $past(err_ev) || $past(unf_ev);
    endproperty
    a_fault_cause: assert property (p_fault_cause)
        else $error("fault raised without underflow or error");

    property p_presc_step;
        $changed(st_ff.presc)
            |-> $past(slow_tick) || $past(mode_wr) || $past(restart_ok);
    endproperty
    a_presc_step: assert property (p_presc_step)
        else $error("prescaler moved without a slow tick or restart");

    property p_irq_off;
        !st_ff.mode.fault_irq_enable |-> !wdt_irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt raised while disabled");

endmodule : wwd_watchdog

// >>> verilog/wwd_pkg.sv
package wwd_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] MODE_OFS  = 8'h04;
    localparam logic [7:0] FLAGS_OFS = 8'h08;
    localparam logic [7:0] ISTAT_OFS = 8'h0C;
    localparam logic [7:0] IMASK_OFS = 8'h10;

    // Control register layout and the key that unlocks it.
    localparam int         KEY_MSB     = 31;
    localparam int         KEY_LSB     = 24;
    localparam int         RESTART_BIT = 0;
    localparam logic [7:0] CTRL_KEY    = 8'hA5;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Clock rates; the slow tick is derived from the system clock.
    localparam int SYS_CLK_HZ  = 25_000_000;
    localparam int SLOW_CLK_HZ = 32_768;
    localparam int SLOW_DIV    = SYS_CLK_HZ / SLOW_CLK_HZ;
    localparam logic [9:0] SLOW_DIV_MAX = 10'(SLOW_DIV - 1);

    // Prescaler divides the slow tick by 128.
    localparam int         PRESC_DIV = 128;
    localparam logic [6:0] PRESC_MAX = 7'(PRESC_DIV - 1);

    // Mode register fields, bit 31 down to bit 0.
    typedef struct packed {
        logic [1:0]  rsvd;                   // Reads as zero.
        logic        idle_halt;              // Stop while system idle.
        logic        debug_halt;             // Stop while core in debug.
        logic [11:0] restart_window_delta;   // Upper edge of restart window.
        logic        timer_disable;          // Counter does not run.
        logic        core_only_reset_select; // Fault resets core only.
        logic        fault_reset_enable;     // Fault requests a reset.
        logic        fault_irq_enable;       // Fault raises interrupt.
        logic [11:0] counter_load_value;     // Reload value of counter.
    } wwd_mode_s;

    localparam wwd_mode_s MODE_RST  = 32'h3FFF_2FFF;
    localparam logic [31:0] MODE_WMASK = 32'h3FFF_FFFF;
    localparam logic [1:0] IMASK_RST = 2'h3;

    // Whole state of the watchdog, registered as one word.
    typedef struct packed {
        logic        aw_have;  // Write address held.
        logic [7:0]  aw_addr;  // Held write address.
        logic        w_have;   // Write data held.
        logic [31:0] w_data;   // Held write data.
        logic [3:0]  w_strb;   // Held byte strobes.
        logic        awready;  // Write address channel ready.
        logic        wready;   // Write data channel ready.
        logic        bvalid;   // Write response pending.
        logic [1:0]  bresp;    // Write response code.
        logic        arready;  // Read address channel ready.
        logic        rvalid;   // Read data pending.
        logic [1:0]  rresp;    // Read response code.
        logic [31:0] rdata;    // Read data.
        wwd_mode_s   mode;     // Mode register.
        logic        locked;   // Mode register already written.
        logic [11:0] cnt;      // Watchdog down counter.
        logic [6:0]  presc;    // Divide-by-128 prescaler.
        logic [9:0]  sdiv;     // Slow tick divider.
        logic        unf;      // Sticky underflow flag.
        logic        err;      // Sticky early restart error flag.
        logic [1:0]  istat;    // Interrupt status, write one to clear.
        logic [1:0]  imask;    // Interrupt mask.
        logic        fault;    // Fault line to reset controller.
        logic        core_rst; // Processor reset request.
        logic        sys_rst;  // All resets request.
        logic        irq;      // Interrupt output.
    } wwd_state_s;

    localparam wwd_state_s STATE_RST = '{
        mode    : MODE_RST,
        imask   : IMASK_RST,
        awready : 1'b1,
        wready  : 1'b1,
        arready : 1'b1,
        default : '0
    };

endpackage : wwd_pkg

// >>> test/wwd_rstc_model.sv
// Reset controller model: a processor reset request comes back on reset.
module wwd_rstc_model (
    input  wire logic sys_clk,        // System clock.
    input  wire logic core_reset_req, // Processor reset request.
    output logic      wdt_rst_n       // Watchdog reset, active low.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] dly_ff = 4'h0; // Delay, then low phase, of the reset.

    // Wait four cycles, then hold reset low for four so it is seen first.
    always_ff @(posedge sys_clk)
    begin
        if (dly_ff != 4'h0)
            dly_ff <= dly_ff - 4'h1;
        else if (core_reset_req)
            dly_ff <= 4'h8;
    end
    assign wdt_rst_n = !(dly_ff != 4'h0 && dly_ff < 4'h5);
endmodule : wwd_rstc_model

// >>> test/wwd_tb.sv
// Register-level bench for the watchdog; halt inputs rise in one scenario.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, por_n, wdt_rst_n, rst_n;  // Clock and resets.
    logic [7:0]  awaddr, araddr;                    // Bus addresses.
    logic        awvalid, wvalid, bready, arvalid, rready; // Strobes.
    logic [31:0] wdata, rdata, lrd;                 // Data, last read.
    logic [3:0]  wstrb;                             // Byte strobes.
    logic [1:0]  bresp, rresp, lresp;               // Responses.
    logic        awready, wready, bvalid, arready, rvalid; // Readies.
    logic        fault, core_req, sys_req, irq;     // Far side lines.
    logic        dbg, idle;                         // Halt inputs.
    int          n_fail = 0, num_checks = 0;        // Tallies.
    assign rst_n = por_n & wdt_rst_n;
    wwd_watchdog DUT (.sys_clk(sys_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .debug_state(dbg), .idle_state(idle),
        .wdt_fault(fault), .core_reset_req(core_req),
        .system_reset_req(sys_req), .wdt_irq(irq));
    wwd_rstc_model rstc (.sys_clk(sys_clk), .core_reset_req(core_req),
        .wdt_rst_n(wdt_rst_n));
    // Free-running 25 MHz clock.
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Report a mismatch at once and keep the tally.
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One write; address and data are each released when taken.
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic got;
        got = 1'b0;
        @(posedge sys_clk);
        awaddr <= a; wdata <= d; wstrb <= 4'hF;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!got)
        begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid)
            begin
                got = 1'b1;
                lresp = bresp;
                bready <= 1'b0;
            end
        end
    endtask : axw
    // One read; the answer is taken at the edge that sees rvalid.
    task automatic axr(input logic [7:0] a);
        logic got;
        got = 1'b0;
        @(posedge sys_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!got)
        begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid)
            begin
                got = 1'b1;
                lrd = rdata;
                lresp = rresp;
                rready <= 1'b0;
            end
        end
    endtask : axr
    // Reset values, write-only and unmapped places.
    task automatic t_reset_vals();
        axr(wwd_pkg::MODE_OFS);  chk("mode", 32'h3FFF_2FFF, lrd);
        axr(wwd_pkg::FLAGS_OFS); chk("flags", 32'h0000_0000, lrd);
        axr(wwd_pkg::CTRL_OFS);  chk("ctrl", 32'h0000_0000, lrd);
        axr(8'h20); chk("unmapped", 32'(wwd_pkg::RESP_SLVERR), 32'(lresp));
        axw(wwd_pkg::CTRL_OFS, 32'hA500_0001); // Window open wide here.
        chk("wr resp", 32'(wwd_pkg::RESP_OKAY), 32'(lresp));
        axr(wwd_pkg::FLAGS_OFS); chk("no err", 32'h0000_0000, lrd);
    endtask : t_reset_vals
    // Small window, reload 0x100; only the first mode write sticks.
    task automatic t_mode_once();
        // Mode writes wait out three slow periods after the last restart.
        repeat (3 * wwd_pkg::SLOW_DIV + 1) @(posedge sys_clk);
        axw(wwd_pkg::MODE_OFS, 32'h0010_1100); // Enabled.
        axw(wwd_pkg::MODE_OFS, 32'h0000_0FFF);
        axr(wwd_pkg::MODE_OFS); chk("mode once", 32'h0010_1100, lrd);
        axw(wwd_pkg::CTRL_OFS, 32'h5A00_0001);
        axr(wwd_pkg::FLAGS_OFS); chk("bad key", 32'h0000_0000, lrd);
    endtask : t_mode_once
    // Early restart: error, masked and unmasked interrupt, clear on read.
    task automatic t_early();
        axw(wwd_pkg::IMASK_OFS, 32'h0000_0000);
        axw(wwd_pkg::CTRL_OFS, 32'hA500_0001); // Mode stays untouched after.
        repeat (2) @(posedge sys_clk);
        chk("fault", 32'h1, 32'(fault));
        chk("irq masked", 32'h0, 32'(irq));
        chk("no reset", 32'h0, 32'(core_req));
        axw(wwd_pkg::IMASK_OFS, 32'h0000_0003);
        repeat (2) @(posedge sys_clk);
        chk("irq", 32'h1, 32'(irq));
        axw(wwd_pkg::ISTAT_OFS, 32'h0000_0002);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", 32'h0, 32'(irq));
        axr(wwd_pkg::FLAGS_OFS); chk("err flag", 32'h0000_0002, lrd);
        repeat (2) @(posedge sys_clk);
        chk("fault off", 32'h0, 32'(fault));
        axr(wwd_pkg::FLAGS_OFS);
        chk("flags clr", 32'h0000_0000, lrd);
    endtask : t_early
    // Second reset, then an error with resets on brings the reset back.
    task automatic t_fault_reset();
        logic cs, ss;
        cs = 1'b0;
        ss = 1'b0;
        por_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        por_n <= 1'b1;
        // Both halts armed and in force; the error must still fault.
        axw(wwd_pkg::MODE_OFS, 32'h3000_2FFF);
        dbg <= 1'b1;
        idle <= 1'b1;
        axw(wwd_pkg::CTRL_OFS, 32'hA500_0001);
        repeat (12)
        begin
            @(posedge sys_clk);
            if (core_req === 1'b1) cs = 1'b1;
            if (sys_req === 1'b1) ss = 1'b1;
        end
        dbg <= 1'b0;
        idle <= 1'b0;
        chk("core req", 32'h1, 32'(cs));
        chk("system req", 32'h1, 32'(ss));
        axr(wwd_pkg::MODE_OFS); chk("mode back", 32'h3FFF_2FFF, lrd);
        axr(wwd_pkg::FLAGS_OFS);
        chk("flags rst", 32'h0000_0000, lrd);
    endtask : t_fault_reset
    // Core-only select: the error resets the processor, not the system.
    // The watchdog reset above cleared the restart, so no wait is due.
    task automatic t_core_only();
        logic cs, ss;
        cs = 1'b0;
        ss = 1'b0;
        axw(wwd_pkg::MODE_OFS, 32'h0000_6FFF);
        axw(wwd_pkg::CTRL_OFS, 32'hA500_0001);
        repeat (12)
        begin
            @(posedge sys_clk);
            if (core_req === 1'b1) cs = 1'b1;
            if (sys_req === 1'b1) ss = 1'b1;
        end
        chk("core only", 32'h1, 32'(cs));
        chk("no system", 32'h0, 32'(ss));
        axr(wwd_pkg::FLAGS_OFS);
        chk("flags rst2", 32'h0000_0000, lrd);
    endtask : t_core_only
    // Print the verdict and stop.
    task automatic wrap_up();
        if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up
    // Main sequence.
    initial
    begin
        por_n = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = '0;
        wstrb = 4'h0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0;
        dbg = 1'b0;
        idle = 1'b0;
        repeat (5) @(posedge sys_clk);
        por_n <= 1'b1;
        t_reset_vals();
        t_mode_once();
        t_early();
        t_fault_reset();
        t_core_only();
        wrap_up();
    end
    // Hang guard, far beyond the roughly 2,400 cycles the tests need.
    initial
    begin
        #400000;
        n_fail++;
        wrap_up();
    end
endmodule : testbench
